// >>> shared/esd_pkg.sv
`default_nettype none
package esd_pkg;
   // register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // register indices on the plain port
   localparam logic [ADDR_W-1:0] OFS_DELAY_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_STEER_CTRL = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_SHDN_CTRL  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 3'h4;

   // restart and delay control fields
   localparam int POS_AUTO_RESTART = 7;
   localparam int POS_DELAY_LSB    = 0;
   localparam int DELAY_W          = 7;

   // pulse steering fields
   localparam int POS_CMPL_LSB     = 6;
   localparam int POS_STEER_SYNC   = 4;
   localparam int POS_STEER_LSB    = 0;

   // auto-shutdown control fields
   localparam int POS_SHDN_FLAG    = 7;
   localparam int POS_SHDN_SRC_LSB = 4;
   localparam int POS_PSS_AC_LSB   = 2;
   localparam int POS_PSS_BD_LSB   = 0;

   // interrupt status bits
   localparam int POS_IRQ_SHDN     = 0;
   localparam int POS_IRQ_RESTART  = 1;
   localparam int IRQ_W            = 2;

   // reset values
   localparam logic [7:0] RST_DELAY_CTRL = 8'h00;
   localparam logic [7:0] RST_STEER_CTRL = 8'h01;
   localparam logic [6:0] RST_SHDN_CTRL  = 7'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ  = 2'h0;

   // complementary pair select codes
   typedef enum logic [1:0]
   {
      CMPL_OFF = 2'b00,
      CMPL_AB  = 2'b01,
      CMPL_AC  = 2'b10,
      CMPL_RSV = 2'b11
   } esd_cmpl_t;

   // pin indices
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_C = 2;
   localparam int PIN_D = 3;
endpackage : esd_pkg
`default_nettype wire

// >>> verilog/esd_top.sv
`timescale 1ns/1ps
`default_nettype none
module esd_top
   import esd_pkg::*;
#(
   parameter int DLY_W = esd_pkg::DELAY_W
)
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [esd_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [esd_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output var  logic [esd_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                       period_start,
   input  wire logic                       pwm_raw,
   input  wire logic                       fault_in,
   input  wire logic [3:0]                 port_out,
   input  wire logic [3:0]                 port_oe,
   output var  logic [3:0]                 pwm_output,
   output var  logic [3:0]                 pwm_output_oe,
   output var  logic                       shutdown_active,
   output var  logic                       irq
);
   import esd_pkg::*;

   // the delay field sits in the low byte beside the restart bit
   if (DLY_W < 1 || DLY_W > POS_AUTO_RESTART)
   begin : g_bad_width
      $error("esd_top: DLY_W must lie between 1 and 7");
   end

   // write strobe decode, shared by several registers
   function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic w, input logic [ADDR_W-1:0] ofs);
      wr_hit = w && (a == ofs);
   endfunction : wr_hit

   logic             fault_meta_q;
   logic             fault_lvl_q;
   logic             auto_restart_q;
   logic [DLY_W-1:0] delay_count_q;
   logic [1:0]       cmpl_sel_q;
   logic             steer_sync_q;
   logic [3:0]       steer_en_q;
   logic             shdn_flag_q;
   logic [2:0]       shdn_src_q;
   logic [1:0]       pss_ac_q;
   logic [1:0]       pss_bd_q;
   logic             running_q;
   logic             raw_prev_q;
   logic             dly_pend_q;
   logic [DLY_W-1:0] dly_cnt_q;
   logic             pwm_dly_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic             shdn_prev_q;
   logic             run_prev_q;
   logic             shdn_wr;
   logic             off_state;
   logic [3:0]       pin_d;
   logic [3:0]       oe_d;
   logic [IRQ_W-1:0] irq_set;

   // two flops on the fault pin; only the second one is looked at
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_meta_q <= 1'b0;
         fault_lvl_q  <= 1'b0;
      end
      else
      begin
         fault_meta_q <= fault_in;
         fault_lvl_q  <= fault_meta_q;
      end
   end

   assign shdn_wr = wr_hit(reg_addr, reg_wr, OFS_SHDN_CTRL);

   // restart and delay control; upper byte has no storage at all
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         auto_restart_q <= RST_DELAY_CTRL[POS_AUTO_RESTART];
         delay_count_q  <= RST_DELAY_CTRL[DLY_W-1:0];
      end
      else if (wr_hit(reg_addr, reg_wr, OFS_DELAY_CTRL))
      begin
         auto_restart_q <= reg_wdata[POS_AUTO_RESTART];
         delay_count_q  <= reg_wdata[POS_DELAY_LSB +: DLY_W];
      end
   end

   // pulse steering control
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmpl_sel_q   <= RST_STEER_CTRL[POS_CMPL_LSB +: 2];
         steer_sync_q <= RST_STEER_CTRL[POS_STEER_SYNC];
         steer_en_q   <= RST_STEER_CTRL[POS_STEER_LSB +: 4];
      end
      else if (wr_hit(reg_addr, reg_wr, OFS_STEER_CTRL))
      begin
         cmpl_sel_q   <= reg_wdata[POS_CMPL_LSB +: 2];
         steer_sync_q <= reg_wdata[POS_STEER_SYNC];
         steer_en_q   <= reg_wdata[POS_STEER_LSB +: 4];
      end
   end

   // shutdown state fields and stored source select
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shdn_src_q <= RST_SHDN_CTRL[POS_SHDN_SRC_LSB +: 3];
         pss_ac_q   <= RST_SHDN_CTRL[POS_PSS_AC_LSB +: 2];
         pss_bd_q   <= RST_SHDN_CTRL[POS_PSS_BD_LSB +: 2];
      end
      else if (shdn_wr)
      begin
         shdn_src_q <= reg_wdata[POS_SHDN_SRC_LSB +: 3];
         pss_ac_q   <= reg_wdata[POS_PSS_AC_LSB +: 2];
         pss_bd_q   <= reg_wdata[POS_PSS_BD_LSB +: 2];
      end
   end

   // shutdown flag: the fault level wins over any clear, auto or manual
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shdn_flag_q <= 1'b0;
      end
      else if (fault_lvl_q)
      begin
         shdn_flag_q <= 1'b1;
      end
      else if (shdn_wr)
      begin
         shdn_flag_q <= reg_wdata[POS_SHDN_FLAG];
      end
      else if (auto_restart_q)
      begin
         shdn_flag_q <= 1'b0;
      end
   end

   // waveform gate: reopens only on a period start after the flag is clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         running_q <= 1'b0;
      end
      else if (shdn_flag_q || fault_lvl_q)
      begin
         running_q <= 1'b0;
      end
      else if (period_start)
      begin
         running_q <= 1'b1;
      end
   end

   // active-edge delay; falling edges pass at once so pulses only shrink
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_prev_q <= 1'b0;
         dly_pend_q <= 1'b0;
         dly_cnt_q  <= '0;
         pwm_dly_q  <= 1'b0;
      end
      else
      begin
         raw_prev_q <= pwm_raw;
         if (!pwm_raw)
         begin
            dly_pend_q <= 1'b0;
            pwm_dly_q  <= 1'b0;
         end
         else if (!raw_prev_q)
         begin
            if (delay_count_q == '0)
            begin
               pwm_dly_q <= 1'b1;
            end
            else
            begin
               dly_pend_q <= 1'b1;
               dly_cnt_q  <= delay_count_q;
            end
         end
         else if (dly_pend_q)
         begin
            dly_cnt_q <= dly_cnt_q - 1'b1;
            if (dly_cnt_q == DLY_W'(1))
            begin
               dly_pend_q <= 1'b0;
               pwm_dly_q  <= 1'b1;
            end
         end
      end
   end

   // steering and pairing; reserved select 11 behaves like 00
   always_comb
   begin
      off_state = shdn_flag_q || !running_q;
      pin_d     = port_out;
      oe_d      = port_oe;
      case (esd_cmpl_t'(cmpl_sel_q))
         CMPL_AC:
         begin
            pin_d[PIN_A] = pwm_dly_q;
            pin_d[PIN_C] = !pwm_dly_q;
            oe_d[PIN_A]  = 1'b1;
            oe_d[PIN_C]  = 1'b1;
            if (off_state)
            begin
               pin_d[PIN_A] = pss_ac_q[0];
               pin_d[PIN_C] = pss_ac_q[0];
               oe_d[PIN_A]  = !pss_ac_q[1];
               oe_d[PIN_C]  = !pss_ac_q[1];
            end
         end
         CMPL_AB:
         begin
            pin_d[PIN_A] = pwm_dly_q;
            pin_d[PIN_B] = !pwm_dly_q;
            oe_d[PIN_A]  = 1'b1;
            oe_d[PIN_B]  = 1'b1;
            if (off_state)
            begin
               pin_d[PIN_A] = pss_ac_q[0];
               oe_d[PIN_A]  = !pss_ac_q[1];
               pin_d[PIN_B] = pss_bd_q[0];
               oe_d[PIN_B]  = !pss_bd_q[1];
            end
         end
         default:
         begin
            for (int i = 0; i < 4; i++)
            begin
               if (steer_en_q[i])
               begin
                  pin_d[i] = pwm_dly_q;
                  oe_d[i]  = 1'b1;
                  if (off_state)
                  begin
                     // pins A and C share one field, B and D the other
                     pin_d[i] = (i % 2 == 0) ? pss_ac_q[0] : pss_bd_q[0];
                     oe_d[i]  = (i % 2 == 0) ? !pss_ac_q[1] : !pss_bd_q[1];
                  end
               end
            end
         end
      endcase
   end

   // pins straight from flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwm_output      <= 4'h0;
         pwm_output_oe   <= 4'h0;
         shutdown_active <= 1'b0;
      end
      else
      begin
         pwm_output      <= pin_d;
         pwm_output_oe   <= oe_d;
         shutdown_active <= shdn_flag_q;
      end
   end

   // interrupt events: shutdown entry and waveform restart
   assign irq_set[POS_IRQ_SHDN]    = shdn_flag_q && !shdn_prev_q;
   assign irq_set[POS_IRQ_RESTART] = running_q && !run_prev_q;

   // sticky status; an event in the clearing cycle survives
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shdn_prev_q <= 1'b0;
         run_prev_q  <= 1'b0;
         irq_stat_q  <= RST_IRQ;
         irq_mask_q  <= RST_IRQ;
         irq         <= 1'b0;
      end
      else
      begin
         shdn_prev_q <= shdn_flag_q;
         run_prev_q  <= running_q;
         if (wr_hit(reg_addr, reg_wr, OFS_IRQ_STAT))
         begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_set;
         end
         else
         begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (wr_hit(reg_addr, reg_wr, OFS_IRQ_MASK))
         begin
            irq_mask_q <= reg_wdata[IRQ_W-1:0];
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= '0;
      end
      else
      begin
         reg_rdata <= '0;
         if (reg_rd)
         begin
            if (reg_addr == OFS_DELAY_CTRL)
            begin
               reg_rdata[POS_AUTO_RESTART]           <= auto_restart_q;
               reg_rdata[POS_DELAY_LSB +: DLY_W]     <= delay_count_q;
            end
            else if (reg_addr == OFS_STEER_CTRL)
            begin
               reg_rdata[POS_CMPL_LSB +: 2]  <= cmpl_sel_q;
               reg_rdata[POS_STEER_SYNC]     <= steer_sync_q;
               reg_rdata[POS_STEER_LSB +: 4] <= steer_en_q;
            end
            else if (reg_addr == OFS_SHDN_CTRL)
            begin
               reg_rdata[POS_SHDN_FLAG]           <= shdn_flag_q;
               reg_rdata[POS_SHDN_SRC_LSB +: 3]   <= shdn_src_q;
               reg_rdata[POS_PSS_AC_LSB +: 2]     <= pss_ac_q;
               reg_rdata[POS_PSS_BD_LSB +: 2]     <= pss_bd_q;
            end
            else if (reg_addr == OFS_IRQ_STAT)
            begin
               reg_rdata[IRQ_W-1:0] <= irq_stat_q;
            end
            else if (reg_addr == OFS_IRQ_MASK)
            begin
               reg_rdata[IRQ_W-1:0] <= irq_mask_q;
            end
         end
      end
   end

   // checks beside the logic
   fault_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
      fault_lvl_q |=> shdn_flag_q && !running_q)
      else $error("shutdown flag dropped while fault present");

   flag_write_a : assert property (@(posedge clk) disable iff (!rst_n)
      (fault_lvl_q && shdn_wr && !reg_wdata[POS_SHDN_FLAG]) |=> shdn_flag_q)
      else $error("flag write took effect during fault");

   restart_period_a : assert property (@(posedge clk) disable iff (!rst_n)
      $rose(running_q) |-> $past(period_start) && !$past(shdn_flag_q))
      else $error("waveform restarted off a period start");

   auto_clear_a : assert property (@(posedge clk) disable iff (!rst_n)
      (shdn_flag_q && !fault_lvl_q && auto_restart_q && !shdn_wr) |=> !shdn_flag_q)
      else $error("auto restart did not clear flag");

   manual_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
      (shdn_flag_q && !auto_restart_q && !shdn_wr) |=> shdn_flag_q)
      else $error("flag cleared without software");

   delay_zero_a : assert property (@(posedge clk) disable iff (!rst_n)
      (pwm_raw && !raw_prev_q && delay_count_q == '0) |=> pwm_dly_q)
      else $error("zero delay edge not passed at once");

   delay_rise_a : assert property (@(posedge clk) disable iff (!rst_n)
      $rose(pwm_dly_q) |-> $past(pwm_raw) && ($past(dly_pend_q) || $past(delay_count_q) == '0))
      else $error("active edge without a held raw high");

   comp_ac_a : assert property (@(posedge clk) disable iff (!rst_n)
      (cmpl_sel_q == CMPL_AC && !off_state) |=> pwm_output[PIN_A] == $past(pwm_dly_q) && pwm_output[PIN_C] == !$past(pwm_dly_q))
      else $error("A and C not complementary");

   steer_port_a : assert property (@(posedge clk) disable iff (!rst_n)
      (cmpl_sel_q == CMPL_OFF && !steer_en_q[PIN_A]) |=> pwm_output[PIN_A] == $past(port_out[PIN_A]))
      else $error("unsteered pin A not under port control");

   upper_zero_a : assert property (@(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_DELAY_CTRL) |=> reg_rdata[15:8] == 8'h00)
      else $error("upper byte of delay control not zero");

   shdn_drive_a : assert property (@(posedge clk) disable iff (!rst_n)
      (shdn_flag_q && cmpl_sel_q == CMPL_OFF && steer_en_q[PIN_A] && pss_ac_q == 2'b01)
      |=> pwm_output_oe[PIN_A] && pwm_output[PIN_A])
      else $error("pin A not driven high in shutdown");
endmodule : esd_top
`default_nettype wire

// >>> testbench/esd_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
// power stage with a desaturation detector; trip latency is a parameter so it can be prompt or slow
module esd_bridge_model
#(
   parameter int TRIP_LAT = 1
)
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       trip,
   input  wire logic [3:0] pin,
   input  wire logic [3:0] pin_oe,
   output var  logic       fault_in,
   output var  logic       shoot_through
);
   int unsigned cnt_q;

   // fault level is held for as long as the trip request stays up
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q    <= 0;
         fault_in <= 1'b0;
      end
      else if (!trip)
      begin
         cnt_q    <= 0;
         fault_in <= 1'b0;
      end
      else if (cnt_q >= TRIP_LAT)
         fault_in <= 1'b1;
      else
         cnt_q <= cnt_q + 1;
   end

   // both switches of the a/c leg on together would short the supply
   assign shoot_through = pin_oe[0] && pin_oe[2] && pin[0] && pin[2];
endmodule : esd_bridge_model
`default_nettype wire

// >>> testbench/esd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module esd_top_tb;
   import esd_pkg::*;
   logic              clk, rst_n, reg_wr, reg_rd, period_start, pwm_raw, fault_in, trip, shoot;
   logic              shutdown_active, irq, shut;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_q;
   logic [3:0]        port_out, port_oe, pwm_output, pwm_output_oe, steer;
   logic [1:0]        mode, ac, bd;
   logic [6:0]        dly;
   int                num_errors, checked, n;

   esd_top i_esd_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_start(period_start),
      .pwm_raw(pwm_raw), .fault_in(fault_in), .port_out(port_out), .port_oe(port_oe),
      .pwm_output(pwm_output), .pwm_output_oe(pwm_output_oe), .shutdown_active(shutdown_active),
      .irq(irq));
   // slow partner so the sync path sees a late fault
   esd_bridge_model #(.TRIP_LAT(3)) i_esd_bridge_model (.clk(clk), .rst_n(rst_n), .trip(trip),
      .pin(pwm_output), .pin_oe(pwm_output_oe), .fault_in(fault_in), .shoot_through(shoot));

   // 125 MHz
   always #4 clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data only stands in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd_q = reg_rdata;
   endtask : rd

   task automatic pulse_period();
      @(posedge clk);
      period_start <= 1'b1;
      @(posedge clk);
      period_start <= 1'b0;
   endtask : pulse_period

   // expected {oe, driven value} per pin; undriven pins compare as 0
   function automatic logic [7:0] pins_exp(input logic w);
      logic [3:0] rt, oe, out;
      logic [1:0] f;
      logic       cpl;
      rt = (mode == 2'b10) ? 4'h5 : (mode == 2'b01) ? 4'h3 : steer;
      for (int i = 0; i < 4; i++)
      begin
         f      = (i % 2 == 0) ? ac : bd;
         cpl    = (mode == 2'b10 || mode == 2'b01) && i != 0;
         oe[i]  = !rt[i] ? port_oe[i] : (shut ? !f[1] : 1'b1);
         out[i] = !rt[i] ? port_out[i] : (shut ? f[0] : w ^ cpl);
      end
      return {oe, out & oe};
   endfunction : pins_exp

   function automatic logic [15:0] pins_seen();
      return {8'h00, pwm_output_oe, pwm_output & pwm_output_oe};
   endfunction : pins_seen

   // watchdog at 8000 cycles, far beyond the several hundred cycles the tests need
   initial
   begin
      #(8 * 8000);
      num_errors++;
      print_verdict();
   end

   initial
   begin
      n = $urandom(31015);
      clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
      period_start = 1'b0; pwm_raw = 1'b0; trip = 1'b0;
      port_out = 4'($urandom); port_oe = 4'($urandom);
      mode = 2'b00; steer = 4'h1; ac = 2'b00; bd = 2'b00; shut = 1'b1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, unmapped index and the dead upper byte
      rd(OFS_DELAY_CTRL);
      check(rd_q, 16'h0000);
      rd(OFS_STEER_CTRL);
      check(rd_q, 16'h0001);
      rd(OFS_SHDN_CTRL);
      check(rd_q, 16'h0000);
      rd(3'h7);
      check(rd_q, 16'h0000);
      check(pins_seen(), {8'h00, pins_exp(1'b0)});
      wr(OFS_DELAY_CTRL, 16'hFFFF);
      rd(OFS_DELAY_CTRL);
      check(rd_q, 16'h00FF);
      wr(OFS_DELAY_CTRL, 16'h0000);
      pulse_period();
      shut = 1'b0;
      // every pair select code with random steering, ports and waveform
      for (int i = 0; i < 16; i++)
      begin
         mode  = 2'(i % 4);
         steer = 4'($urandom);
         @(posedge clk);
         port_out <= 4'($urandom);
         port_oe  <= 4'($urandom);
         pwm_raw  <= 1'($urandom);
         wr(OFS_STEER_CTRL, {8'h00, mode, 1'b0, 1'($urandom), steer});
         repeat (5) @(posedge clk);
         #1;
         check(pins_seen(), {8'h00, pins_exp(pwm_raw)});
         if (mode == 2'b10)
            check(shoot, 1'b0);
      end
      // rising edge held back by the delay count, falling edge not
      @(posedge clk);
      pwm_raw <= 1'b0;
      wr(OFS_STEER_CTRL, 16'h0001);
      for (int j = 0; j < 6; j++)
      begin
         dly = (j == 0) ? 7'h00 : (j == 1) ? 7'h7F : 7'(1 + $urandom % 40);
         wr(OFS_DELAY_CTRL, {9'h000, dly});
         @(posedge clk);
         pwm_raw <= 1'b1;
         repeat (dly + 1) @(posedge clk);
         #1;
         check(pwm_output[0], 1'b0);
         @(posedge clk);
         #1;
         check(pwm_output[0], 1'b1);
         @(posedge clk);
         pwm_raw <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
         check(pwm_output[0], 1'b0);
      end
      // shutdown with software restart, then with auto restart
      @(posedge clk);
      pwm_raw <= 1'b1;
      mode  = 2'b00;
      steer = 4'hF;
      wr(OFS_STEER_CTRL, 16'h000F);
      wr(OFS_IRQ_MASK, 16'h0001);
      for (int r = 0; r < 2; r++)
      begin
         ac = 2'($urandom);
         bd = 2'($urandom);
         wr(OFS_DELAY_CTRL, {8'h00, r[0], 7'h00});
         wr(OFS_SHDN_CTRL, {12'h000, ac, bd});
         @(posedge clk);
         trip <= 1'b1;
         shut = 1'b1;
         repeat (14) @(posedge clk);
         #1;
         check(pins_seen(), {8'h00, pins_exp(1'b1)});
         check(shutdown_active, 1'b1);
         check(irq, 1'b1);
         wr(OFS_SHDN_CTRL, {12'h000, ac, bd});
         rd(OFS_SHDN_CTRL);
         check(rd_q, {8'h00, 1'b1, 3'b000, ac, bd});
         repeat (20) @(posedge clk);
         #1;
         check(pins_seen(), {8'h00, pins_exp(1'b1)});
         @(posedge clk);
         trip <= 1'b0;
         repeat (8) @(posedge clk);
         wr(OFS_IRQ_STAT, 16'h0001);
         rd(OFS_SHDN_CTRL);
         check(rd_q, {8'h00, !r[0], 3'b000, ac, bd});
         check(pins_seen(), {8'h00, pins_exp(1'b1)});
         if (r == 0)
            wr(OFS_SHDN_CTRL, {12'h000, ac, bd});
         repeat (4) @(posedge clk);
         #1;
         check(irq, 1'b0);
         check(pins_seen(), {8'h00, pins_exp(1'b1)});
         pulse_period();
         shut = 1'b0;
         repeat (3) @(posedge clk);
         #1;
         check(pins_seen(), {8'h00, pins_exp(1'b1)});
      end
      print_verdict();
   end
endmodule : esd_top_tb
`default_nettype wire
